// ==== design/iepc_pkg.sv ====
// iepc_pkg: shared constants and types of the interrupt and power controller
// assumes an AHB-Lite register slave with word-aligned registers
//
// Behaviour
// R1: enable register, global bit seven, seven sources
// R2: level register, seven source bits, bit seven unused
// R3: forward enabled sources; high preempts low only
// R4: equal levels resolved external A first, watchdog last
// R5: watchdog source only in timer mode
// R6: serial sleep bit stops serial clock
// R7: idle functional blocks get no clock
// R8: running watchdog blocks power-down entry
// R9: power-down stops the oscillator
// R10: power-down wins over idle in one write
// R11: idle/power-down bits set mode, clear on wake
// R12: idle stops only CPU and converter
// R13: idle entry aborts running conversion
// R14: idle takes effect right after the write
// R15: idle keeps all register contents
// R16: enabled interrupt ends idle, CPU vectors
// R17: hardware reset ends idle like power-on
// R18: internal clock is oscillator divided by two
// R19: spare flags plain storage, reserved bits zero
package iepc_pkg;
  localparam int NUM_SRC = 7;
  // register byte addresses
  localparam logic [7:0] ADDR_ENABLE = 8'h00;
  localparam logic [7:0] ADDR_LEVEL = 8'h04;
  localparam logic [7:0] ADDR_POWER = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0C;
  // field positions
  localparam int GLOBAL_EN_BIT = 7;
  localparam int BAUD_BIT = 7;
  localparam int SLEEP_BIT = 6;
  localparam int FLAG1_BIT = 3;
  localparam int FLAG0_BIT = 2;
  localparam int PDOWN_BIT = 1;
  localparam int IDLE_BIT = 0;
  localparam int WDT_SRC = 6;
  localparam int ADC_SRC = 5;
  localparam int TMR_A_SRC = 1;
  localparam int TMR_B_SRC = 3;
  // masks and reset values
  localparam logic [7:0] LEVEL_MASK = 8'h7F;
  localparam logic [7:0] POWER_MASK = 8'hCF;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] VEC_BASE = 8'h03;
  localparam logic [7:0] VEC_STEP = 8'h08;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  typedef enum logic [1:0] {MODE_RUN, MODE_IDLE, MODE_PDOWN} iepc_mode_type;
  // request presented to the CPU core
  typedef struct packed {
    logic valid;
    logic high;
    logic [7:0] vector;
  } iepc_cpu_irq_type;
  // run enables toward the clock gates
  typedef struct packed {
    logic osc_run;
    logic cpu_run;
    logic adc_run;
    logic serial_run;
    logic timer_a_run;
    logic timer_b_run;
  } iepc_gate_type;
endpackage

// ==== design/iepc_arbiter.sv ====
// iepc_arbiter: picks the request to forward to the CPU
// assumes requests already masked by the enable bits
`timescale 1ns/1ps
`default_nettype none
module iepc_arbiter #(
  parameter int N = 7
) (
  input wire logic [N-1:0] req,
  input wire logic [N-1:0] level,
  input wire logic svc_high,
  input wire logic svc_low,
  output iepc_pkg::iepc_cpu_irq_type irq
);
  logic [N-1:0] hi_req;
  logic [N-1:0] lo_req;
  logic [N-1:0] pick;
  logic [7:0] vec;
  // split requests by level
  genvar i;
  generate
    for (i = 0; i < N; i++) begin : g_split
      assign hi_req[i] = req[i] & level[i];
      assign lo_req[i] = req[i] & ~level[i];
    end
  endgenerate
  // lowest index wins inside a level
  always_comb begin
    pick = (|hi_req) ? hi_req : lo_req; // R4
    vec = iepc_pkg::VEC_BASE;
    for (int k = N - 1; k >= 0; k--) begin
      if (pick[k]) begin
        vec = iepc_pkg::VEC_BASE + 8'(k) * iepc_pkg::VEC_STEP; // R4
      end
    end
  end
  // high preempts low service, never the reverse
  always_comb begin
    irq.high = |hi_req;
    irq.vector = vec;
    irq.valid = (irq.high & ~svc_high) | (~irq.high & |lo_req & ~svc_high & ~svc_low); // R3
  end
endmodule
`default_nettype wire

// ==== design/iepc_gate.sv ====
// iepc_gate: run enables for clock gates and the half-rate phase
// assumes clk is the oscillator input and gates sit outside
`timescale 1ns/1ps
`default_nettype none
module iepc_gate (
  input wire logic clk,
  input wire logic rst_n,
  input wire iepc_pkg::iepc_mode_type mode,
  input wire logic serial_sleep,
  input wire logic [1:0] timer_cmd,
  output iepc_pkg::iepc_gate_type gate,
  output logic sys_phase
);
  typedef struct packed {
    logic phase;
  } iepc_gate_state_type;
  iepc_gate_state_type s;
  iepc_gate_state_type next_s;
  logic pdown;
  // divide by two so input duty cycle is irrelevant; frozen when osc stops
  always_comb begin
    next_s = s;
    if (mode != iepc_pkg::MODE_PDOWN) begin
      next_s.phase = ~s.phase; // R18 R9
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end
  assign sys_phase = s.phase;
  assign pdown = (mode == iepc_pkg::MODE_PDOWN);
  // idle stops cpu and converter only
  always_comb begin
    gate.osc_run = ~pdown; // R9
    gate.cpu_run = (mode == iepc_pkg::MODE_RUN); // R12 R14
    gate.adc_run = (mode == iepc_pkg::MODE_RUN); // R12
    gate.serial_run = ~pdown & ~serial_sleep; // R6
    gate.timer_a_run = ~pdown & timer_cmd[0]; // R7
    gate.timer_b_run = ~pdown & timer_cmd[1]; // R7
  end
endmodule
`default_nettype wire

// ==== design/iepc_ctrl.sv ====
// iepc_ctrl: interrupt enable/level registers and power-mode control
// assumes AHB-Lite master with single word transfers, zero wait states
//
// Chosen here: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module iepc_ctrl (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic [5:0] src_req,
  input wire logic wdt_underflow,
  input wire logic wdt_timer_mode,
  input wire logic wdt_running,
  input wire logic [1:0] timer_run_cmd,
  input wire logic cpu_ack,
  input wire logic cpu_reti,
  output iepc_pkg::iepc_cpu_irq_type cpu_irq,
  output iepc_pkg::iepc_gate_type gate,
  output logic adc_abort,
  output logic wdt_chip_reset,
  output logic baud_double,
  output logic sys_phase
);
  typedef struct packed {
    logic [7:0] enable;
    logic [7:0] level;
    logic [7:0] power;
    iepc_pkg::iepc_mode_type mode;
    logic wd_flag;
    logic svc_high;
    logic svc_low;
    logic dp_valid;
    logic dp_write;
    logic [7:0] dp_addr;
    logic [7:0] rdata;
    logic adc_abort;
    logic chip_reset;
  } iepc_state_type;

  iepc_state_type s;
  iepc_state_type next_s;
  logic [iepc_pkg::NUM_SRC-1:0] pending;
  logic [iepc_pkg::NUM_SRC-1:0] masked;
  logic accept;
  logic wr_now;
  logic wake;
  logic [7:0] wdat;
  logic [7:0] status;
  iepc_pkg::iepc_cpu_irq_type arb_irq;

  // requests from peripherals plus the latched watchdog flag
  assign pending = {s.wd_flag, src_req};
  // global and per-source enable both required
  assign masked = s.enable[iepc_pkg::GLOBAL_EN_BIT] ? // R3 R1
    (pending & s.enable[iepc_pkg::NUM_SRC-1:0]) : '0;
  assign wake = |masked; // R16
  assign accept = hsel & hready & (htrans == iepc_pkg::HTRANS_NONSEQ);
  assign wr_now = s.dp_valid & s.dp_write;
  assign wdat = hwdata[7:0];

  iepc_arbiter #(
    .N(iepc_pkg::NUM_SRC)
  ) u_arb (
    .req(masked),
    .level(s.level[iepc_pkg::NUM_SRC-1:0]),
    .svc_high(s.svc_high),
    .svc_low(s.svc_low),
    .irq(arb_irq)
  );

  iepc_gate u_gate (
    .clk(clk),
    .rst_n(rst_n),
    .mode(s.mode),
    .serial_sleep(s.power[iepc_pkg::SLEEP_BIT]),
    .timer_cmd(timer_run_cmd),
    .gate(gate),
    .sys_phase(sys_phase)
  );

  // next-state: bus write, power modes, service levels, read capture
  always_comb begin
    next_s = s;
    next_s.adc_abort = 1'b0;
    next_s.chip_reset = 1'b0;
    next_s.dp_valid = accept;
    next_s.dp_write = hwrite;
    next_s.dp_addr = haddr;

    // register writes land in the data phase
    if (wr_now) begin
      if (s.dp_addr == iepc_pkg::ADDR_ENABLE) begin
        next_s.enable = wdat; // R1
      end else if (s.dp_addr == iepc_pkg::ADDR_LEVEL) begin
        next_s.level = wdat & iepc_pkg::LEVEL_MASK; // R2
      end else if (s.dp_addr == iepc_pkg::ADDR_POWER) begin
        // flags are plain storage, sleep bit gates the serial clock; reserved stay zero
        next_s.power[iepc_pkg::BAUD_BIT] = wdat[iepc_pkg::BAUD_BIT];
        next_s.power[iepc_pkg::SLEEP_BIT] = wdat[iepc_pkg::SLEEP_BIT]; // R6
        next_s.power[iepc_pkg::FLAG1_BIT] = wdat[iepc_pkg::FLAG1_BIT]; // R19
        next_s.power[iepc_pkg::FLAG0_BIT] = wdat[iepc_pkg::FLAG0_BIT]; // R19
        if (wdat[iepc_pkg::PDOWN_BIT]) begin
          // a running watchdog must not be frozen by a stray write
          if (!wdt_running) begin // R8
            next_s.power[iepc_pkg::PDOWN_BIT] = 1'b1; // R11
            next_s.mode = iepc_pkg::MODE_PDOWN; // R9 R10
          end
        end else if (wdat[iepc_pkg::IDLE_BIT]) begin
          next_s.power[iepc_pkg::IDLE_BIT] = 1'b1; // R11
          next_s.mode = iepc_pkg::MODE_IDLE; // R14
          next_s.adc_abort = 1'b1; // R13
        end
      end else if (s.dp_addr == iepc_pkg::ADDR_STATUS) begin
        if (wdat[0]) begin
          next_s.wd_flag = 1'b0; // software clear of watchdog flag
        end
      end
    end

    // any enabled request ends idle or power-down; state otherwise kept
    if (s.mode != iepc_pkg::MODE_RUN && wake) begin
      next_s.mode = iepc_pkg::MODE_RUN; // R16 R15
      next_s.power[iepc_pkg::PDOWN_BIT] = 1'b0; // R11
      next_s.power[iepc_pkg::IDLE_BIT] = 1'b0; // R11
    end

    // cpu takes the vector: mark the level in service
    if (cpu_ack && arb_irq.valid) begin
      if (arb_irq.high) begin
        next_s.svc_high = 1'b1; // R3
      end else begin
        next_s.svc_low = 1'b1; // R3
      end
      // watchdog vector taken clears the watchdog flag
      if (arb_irq.vector == iepc_pkg::VEC_BASE + 8'(iepc_pkg::WDT_SRC) * iepc_pkg::VEC_STEP) begin
        next_s.wd_flag = 1'b0;
      end
    end else if (cpu_reti) begin
      // return closes the innermost level first
      if (s.svc_high) begin
        next_s.svc_high = 1'b0;
      end else begin
        next_s.svc_low = 1'b0;
      end
    end

    // underflow: interrupt in timer mode, chip reset otherwise; set wins
    if (wdt_underflow) begin
      if (wdt_timer_mode) begin
        next_s.wd_flag = 1'b1; // R5
      end else begin
        next_s.chip_reset = 1'b1; // R5
      end
    end

    // read data captured in the address phase, after same-edge writes
    next_s.rdata = s.rdata;
    if (accept && !hwrite) begin
      if (haddr == iepc_pkg::ADDR_ENABLE) begin
        next_s.rdata = next_s.enable;
      end else if (haddr == iepc_pkg::ADDR_LEVEL) begin
        next_s.rdata = next_s.level;
      end else if (haddr == iepc_pkg::ADDR_POWER) begin
        next_s.rdata = next_s.power & iepc_pkg::POWER_MASK; // R19
      end else if (haddr == iepc_pkg::ADDR_STATUS) begin
        next_s.rdata = status;
      end else begin
        next_s.rdata = iepc_pkg::REG_RESET; // unmapped reads zero
      end
    end
  end

  // status view: mode, service levels, flag, request
  always_comb begin
    status = iepc_pkg::REG_RESET;
    status[0] = next_s.wd_flag;
    status[1] = arb_irq.valid;
    status[2] = next_s.svc_low;
    status[3] = next_s.svc_high;
    status[5:4] = next_s.mode;
  end

  // async reset returns every mode to run, as at power-on
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s.enable <= iepc_pkg::REG_RESET;
      s.level <= iepc_pkg::REG_RESET;
      s.power <= iepc_pkg::REG_RESET;
      s.mode <= iepc_pkg::MODE_RUN; // R17
      s.wd_flag <= 1'b0;
      s.svc_high <= 1'b0;
      s.svc_low <= 1'b0;
      s.dp_valid <= 1'b0;
      s.dp_write <= 1'b0;
      s.dp_addr <= iepc_pkg::REG_RESET;
      s.rdata <= iepc_pkg::REG_RESET;
      s.adc_abort <= 1'b0;
      s.chip_reset <= 1'b0;
    end else begin
      s <= next_s;
    end
  end

  // outputs; zero wait, always OKAY
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = {24'h00_0000, s.rdata};
  assign cpu_irq = arb_irq;
  assign adc_abort = s.adc_abort;
  assign wdt_chip_reset = s.chip_reset;
  assign baud_double = s.power[iepc_pkg::BAUD_BIT];
endmodule
`default_nettype wire

// ==== testbench/iepc_ctrl_asserts.sv ====
// iepc_ctrl_asserts: port-level checks of the controller
// assumes binding onto iepc_ctrl, one clock domain
`timescale 1ns/1ps
`default_nettype none
module iepc_ctrl_asserts (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic wdt_underflow,
  input wire logic wdt_timer_mode,
  input wire logic wdt_running,
  input wire logic [1:0] timer_run_cmd,
  input wire iepc_pkg::iepc_cpu_irq_type cpu_irq,
  input wire iepc_pkg::iepc_gate_type gate,
  input wire logic adc_abort,
  input wire logic wdt_chip_reset,
  input wire logic sys_phase
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // underflow seen while the watchdog guards the chip
  sequence wdt_guard_hit;
    wdt_underflow && !wdt_timer_mode;
  endsequence
  a_bus_okay: assert property (hreadyout && !hresp) else $error("bus stalled or erred");
  a_vector_table: assert property (cpu_irq.valid |-> cpu_irq.vector[2:0] == 3'h3 &&
    cpu_irq.vector <= 8'h33) else $error("vector off table");
  // the divider is held until the first edge after release, so skip that edge
  a_phase_toggle: assert property (rst_n && gate.osc_run |=> $changed(sys_phase))
    else $error("phase did not toggle");
  a_phase_frozen: assert property (!gate.osc_run |=> $stable(sys_phase))
    else $error("phase moved in power-down");
  a_chip_reset: assert property (wdt_guard_hit |=> wdt_chip_reset)
    else $error("no chip reset on underflow");
  a_reset_cause: assert property (wdt_chip_reset |-> $past(wdt_underflow && !wdt_timer_mode))
    else $error("chip reset without cause");
  a_timer_gate: assert property (gate.osc_run |-> {gate.timer_b_run, gate.timer_a_run} ==
    timer_run_cmd) else $error("timer clock wrong");
  a_idle_adc: assert property (gate.osc_run && !gate.cpu_run |-> !gate.adc_run)
    else $error("converter runs in idle");
  a_abort_idle: assert property (adc_abort |-> !gate.cpu_run)
    else $error("abort outside idle");
  a_pd_blocked: assert property ($fell(gate.osc_run) |-> !$past(wdt_running))
    else $error("power-down with watchdog on");
endmodule
bind iepc_ctrl iepc_ctrl_asserts u_chk (.clk(clk), .rst_n(rst_n), .hreadyout(hreadyout),
  .hresp(hresp), .wdt_underflow(wdt_underflow), .wdt_timer_mode(wdt_timer_mode),
  .wdt_running(wdt_running), .timer_run_cmd(timer_run_cmd), .cpu_irq(cpu_irq),
  .gate(gate), .adc_abort(adc_abort), .wdt_chip_reset(wdt_chip_reset),
  .sys_phase(sys_phase));
`default_nettype wire

// ==== testbench/iepc_cpu_model.sv ====
// iepc_cpu_model: request sources and the acking cpu core
// assumes one clock; the bench steers raise, drop, ack and return
`timescale 1ns/1ps
`default_nettype none
module iepc_cpu_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire iepc_pkg::iepc_cpu_irq_type cpu_irq,
  input wire logic [5:0] raise,
  input wire logic drop,
  input wire logic auto_ack,
  input wire logic ret,
  output logic [5:0] src_req,
  output logic cpu_ack,
  output logic cpu_reti
);
  logic [5:0] taken;
  // the acked source lets go of its level request
  always_comb begin
    taken = 6'h00;
    if (cpu_ack && cpu_irq.vector < 8'h33) begin
      taken[cpu_irq.vector[5:3]] = 1'b1;
    end
  end
  // acks only when told, so plain cases see raw requests
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      src_req <= 6'h00;
      cpu_ack <= 1'b0;
      cpu_reti <= 1'b0;
    end else begin
      src_req <= drop ? 6'h00 : (src_req | raise) & ~taken;
      cpu_ack <= auto_ack && cpu_irq.valid && !cpu_ack;
      cpu_reti <= ret;
    end
  end
endmodule
`default_nettype wire

// ==== testbench/irq_enable_power_ctrl_tb_top.sv ====
// irq_enable_power_ctrl_tb_top: self-checking bench of iepc_ctrl
// assumes zero-wait slave and the cpu model beside it
`timescale 1ns/1ps
`default_nettype none
module irq_enable_power_ctrl_tb_top;
  typedef struct packed {logic [7:0] ie, ip; logic [5:0] rq; logic [7:0] vec;} iepc_row_type;
  iepc_row_type rows [8] = '{'{8'h81, 8'h00, 6'h01, 8'h03}, '{8'h01, 8'h00, 6'h01, 8'h00},
    '{8'h80, 8'h00, 6'h01, 8'h00}, '{8'h9F, 8'h00, 6'h1F, 8'h03}, '{8'h9F, 8'h08, 6'h1F, 8'h1B},
    '{8'hBE, 8'h00, 6'h3E, 8'h0B}, '{8'hB0, 8'h00, 6'h30, 8'h23}, '{8'hA0, 8'h00, 6'h20, 8'h2B}};
  logic clk, rst_n, hwrite, hreadyout, hresp, wdt_underflow, wdt_timer_mode, wdt_running;
  logic cpu_ack, cpu_reti, adc_abort, wdt_chip_reset, baud_double, sys_phase, drop, auto_ack, ret;
  logic [7:0] haddr, rd;
  logic [1:0] htrans, timer_run_cmd;
  logic [31:0] hwdata, hrdata;
  logic [5:0] src_req, raise;
  iepc_pkg::iepc_cpu_irq_type cpu_irq;
  iepc_pkg::iepc_gate_type gate;
  int num_errors = 0;
  int total_checks = 0;
  int aborts = 0;
  iepc_ctrl dut (.clk(clk), .rst_n(rst_n), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .src_req(src_req), .wdt_underflow(wdt_underflow),
    .wdt_timer_mode(wdt_timer_mode), .wdt_running(wdt_running), .timer_run_cmd(timer_run_cmd),
    .cpu_ack(cpu_ack), .cpu_reti(cpu_reti), .cpu_irq(cpu_irq), .gate(gate), .adc_abort(adc_abort),
    .wdt_chip_reset(wdt_chip_reset), .baud_double(baud_double), .sys_phase(sys_phase));
  iepc_cpu_model u_cpu (.clk(clk), .rst_n(rst_n), .cpu_irq(cpu_irq), .raise(raise), .drop(drop),
    .auto_ack(auto_ack), .ret(ret), .src_req(src_req), .cpu_ack(cpu_ack), .cpu_reti(cpu_reti));
  // free-running clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // abort pulses counted as they appear
  always @(posedge clk) if (adc_abort === 1'b1) aborts++;
  task stop_test;
    if (num_errors == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task chk(input string nm, input logic [7:0] e, input logic [7:0] s);
    total_checks++;
    if (s !== e) begin
      $display("mismatch %s expected %h seen %h", nm, e, s);
      num_errors++;
    end
  endtask
  // one single transfer; holds each phase until hready is seen high
  task bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    haddr <= a;
    hwrite <= w;
    htrans <= iepc_pkg::HTRANS_NONSEQ;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata[7:0];
    #1;
  endtask
  // one-edge pulse of the model's inputs
  task pulse(input logic [5:0] r, input logic dr);
    @(posedge clk);
    raise <= r;
    drop <= dr;
    @(posedge clk);
    raise <= 6'h00;
    drop <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
  endtask
  initial begin
    {rst_n, hwrite, wdt_underflow, wdt_timer_mode, wdt_running, drop, auto_ack, ret} = '0;
    {haddr, htrans, timer_run_cmd, hwdata, raise} = '0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    bus(0, iepc_pkg::ADDR_ENABLE, 0); chk("enable reset", iepc_pkg::REG_RESET, rd);
    foreach (rows[i]) begin
      bus(1, iepc_pkg::ADDR_ENABLE, rows[i].ie);
      bus(1, iepc_pkg::ADDR_LEVEL, rows[i].ip);
      pulse(rows[i].rq, 1'b0);
      chk("irq valid", rows[i].vec != 8'h00, cpu_irq.valid);
      if (rows[i].vec != 8'h00) chk("irq vector", rows[i].vec, cpu_irq.vector);
      pulse(6'h00, 1'b1);
    end
    bus(1, iepc_pkg::ADDR_LEVEL, 8'hFF);
    bus(0, iepc_pkg::ADDR_LEVEL, 0); chk("level", 8'h7F, rd);
    bus(1, iepc_pkg::ADDR_POWER, 8'hFC);
    bus(0, iepc_pkg::ADDR_POWER, 0); chk("power", 8'hCC, rd);
    chk("serial clock", 0, gate.serial_run);
    chk("baud", 1, baud_double);
    bus(0, 8'h10, 0); chk("unmapped", 0, rd);
    bus(1, iepc_pkg::ADDR_POWER, 8'h00);
    bus(1, iepc_pkg::ADDR_ENABLE, 8'hC0);
    @(posedge clk) {wdt_timer_mode, wdt_underflow} <= 2'b11;
    @(posedge clk) wdt_underflow <= 1'b0;
    #1 chk("timer vector", 8'h33, cpu_irq.vector);
    bus(0, iepc_pkg::ADDR_STATUS, 0); chk("status flag", 8'h03, rd);
    bus(1, iepc_pkg::ADDR_STATUS, 8'h01);
    @(posedge clk) {wdt_timer_mode, wdt_underflow} <= 2'b01;
    @(posedge clk) wdt_underflow <= 1'b0;
    #1 chk("chip reset", 1, wdt_chip_reset);
    chk("no wdt irq", 0, cpu_irq.valid);
    bus(1, iepc_pkg::ADDR_ENABLE, 8'h81);
    @(posedge clk) wdt_running <= 1'b1;
    bus(1, iepc_pkg::ADDR_POWER, 8'h02); chk("pd blocked", 1, gate.osc_run);
    @(posedge clk) wdt_running <= 1'b0;
    bus(1, iepc_pkg::ADDR_POWER, 8'h03); chk("pd osc", 0, gate.osc_run);
    chk("pd wins", 0, gate.cpu_run);
    pulse(6'h01, 1'b0); chk("pd wake", 1, gate.osc_run);
    bus(0, iepc_pkg::ADDR_POWER, 0); chk("bits clear", 0, rd);
    pulse(6'h00, 1'b1);
    @(posedge clk) timer_run_cmd <= 2'b01;
    bus(1, iepc_pkg::ADDR_POWER, 8'h01); chk("idle cpu", 0, gate.cpu_run);
    chk("idle adc", 0, gate.adc_run);
    chk("idle timers", 8'h01, {gate.timer_b_run, gate.timer_a_run});
    chk("idle serial", 1, gate.serial_run);
    chk("abort", 1, adc_abort);
    bus(0, iepc_pkg::ADDR_ENABLE, 0); chk("kept", 8'h81, rd);
    chk("abort count", 1, aborts);
    bus(0, iepc_pkg::ADDR_STATUS, 0); chk("status idle", 8'h10, rd);
    pulse(6'h01, 1'b0); chk("idle wake", 1, gate.cpu_run);
    chk("wake vector", 8'h03, cpu_irq.vector);
    pulse(6'h00, 1'b1);
    bus(1, iepc_pkg::ADDR_POWER, 8'h01);
    @(posedge clk) rst_n <= 1'b0;
    @(posedge clk) rst_n <= 1'b1;
    #1 chk("reset wake", 1, gate.cpu_run);
    bus(1, iepc_pkg::ADDR_ENABLE, 8'h87);
    bus(1, iepc_pkg::ADDR_LEVEL, 8'h02);
    @(posedge clk) auto_ack <= 1'b1;
    pulse(6'h01, 1'b0);
    @(posedge clk) auto_ack <= 1'b0;
    pulse(6'h04, 1'b0); chk("low refused", 0, cpu_irq.valid);
    pulse(6'h02, 1'b0); chk("preempt", 8'h0B, cpu_irq.vector);
    chk("preempt high", 1, cpu_irq.high);
    bus(0, iepc_pkg::ADDR_STATUS, 0); chk("status svc", 8'h06, rd);
    // return from the low routine frees the low level again
    @(posedge clk) ret <= 1'b1;
    @(posedge clk) ret <= 1'b0;
    bus(0, iepc_pkg::ADDR_STATUS, 0); chk("status reti", 8'h02, rd);
    stop_test();
  end
  // hang guard, well past the expected run
  initial begin
    #(25 * 5000);
    num_errors++;
    stop_test();
  end
endmodule
`default_nettype wire
